// *** logic/vmt_consts.svh ***
/*
 Constants of the VLAN and learned-address lookup block and its controller.
 Assumes inclusion by both ends; definitions only.
*/
// Summary of operation
// - Learned table: 1024 entries, host reads only.
// - Bit 71 marks not ready; host rereads.
// - Bit 66 empty flag, reset one.
// - Bits 65-56 hold valid count minus one.
// - Bits 55-54 hold two-bit aging stamp.
// - Bits 53-52 hold learning port code.
// - Filter id 51-48, address 47-0, zero reset.
// - Learned read: control 0x1800+index, top first.
// - Then words 63-48, 47-32, 31-16, 15-0.
// - VLAN table used only with mode bit 15.
// - Sixteen 20-bit VLAN entries, valid bit 19.
// - Membership 18-16 floods misses; reset 111.
// - Bits 15-12 filter id used in lookups.
// - Bits 11-0 VLAN id, reset 0x001.
// - Untagged or null id takes port default.
// - Invalid VLAN id: drop, no learning.
// - Destination miss floods members except ingress.
// - Source miss learns filter id and address.
// - VLAN read: control 0x1400+index, high then low.
// - VLAN write: high, low, then control 0x0400+index.
// - Static destination hit beats learned hit.
// - Source lookup searches learned table only.
`ifndef VMT_CONSTS_SVH
`define VMT_CONSTS_SVH
`define VMT_LT_DEPTH    1024
`define VMT_VT_DEPTH    16
`define VMT_VT_RST      20'hf0001
`define VMT_VT_VALID    19
`define VMT_VLAN_MODE   15
`define VMT_IAC_READ    12
`define VMT_TOP_BUSY    7
// Indirect register selects on the link
`define VMT_SEL_CTRL    3'h0
`define VMT_SEL_TOP     3'h1
`define VMT_SEL_W63     3'h2
`define VMT_SEL_W47     3'h3
`define VMT_SEL_W31     3'h4
`define VMT_SEL_W15     3'h5
`define VMT_SEL_GCTL    3'h6
// Controller Avalon word offsets
`define VMT_AV_CMD      3'h0
`define VMT_AV_VDATA    3'h1
`define VMT_AV_GCTL     3'h2
`define VMT_AV_STATUS   3'h3
`define VMT_AV_RTOP     3'h4
`define VMT_AV_RHI      3'h5
`define VMT_AV_RLO      3'h6
`endif

// *** logic/vmt_pkg.sv ***
/*
 Types shared by the lookup device and its controller.
 Assumes nothing of its surroundings.
*/
package vmt_pkg;
   typedef enum logic [2:0] {
      vmt_s_idle = 3'b000,
      vmt_s_vlan = 3'b001,
      vmt_s_da   = 3'b011,
      vmt_s_sa   = 3'b010,
      vmt_s_lrn  = 3'b110
   } vmt_eng_type;
   typedef enum logic [1:0] {
      vmt_h_idle = 2'b00,
      vmt_h_req  = 2'b01,
      vmt_h_next = 2'b11
   } vmt_hst_type;
   typedef enum logic [1:0] {
      vmt_k_gctl = 2'b00,
      vmt_k_vrd  = 2'b01,
      vmt_k_vwr  = 2'b10,
      vmt_k_lrd  = 2'b11
   } vmt_kind_type;
   typedef struct packed {
      logic [1:0]  stamp;
      logic [1:0]  port;
      logic [3:0]  filter_identifier;
      logic [47:0] mac;
   } vmt_lent_type;
endpackage : vmt_pkg

// *** logic/vmt_if.sv ***
/*
 Indirect register link between controller and lookup device.
 Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface vmt_if;
   logic [2:0]  sel;
   logic        wr;
   logic        rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   modport dev  (input sel, wr, rd, wdata, output rdata, ack);
   modport host (output sel, wr, rd, wdata, input rdata, ack);
endinterface : vmt_if
`default_nettype wire

// *** logic/vmt_dev.sv ***
/*
 Lookup device: VLAN table, learned address table, packet engine and the
 indirect registers. Assumes one request at a time on the link, held until
 ack, and packet requests from logic on clk_sys.
*/
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vmt_consts.svh"
module vmt_dev (
   // System
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // Register link
   vmt_if.dev               rl,
   // Packet request
   input  wire logic        pkt_valid,
   input  wire logic [1:0]  pkt_port,
   input  wire logic        pkt_tagged,
   input  wire logic [11:0] pkt_tag_vid,
   input  wire logic [11:0] pkt_pvid,
   input  wire logic [47:0] pkt_da,
   input  wire logic [47:0] pkt_sa,
   input  wire logic        st_hit,
   input  wire logic [2:0]  st_ports,
   input  wire logic        age_tick,
   // Result
   output logic             pkt_ready,
   output logic             res_valid,
   output logic             res_drop,
   output logic [2:0]       res_ports
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   vmt_pkg::vmt_eng_type  st_q;
   vmt_pkg::vmt_lent_type lt_mem [`VMT_LT_DEPTH];
   vmt_pkg::vmt_lent_type lt_rd_q;
   logic [1023:0]         lt_vld_q;
   logic                  lt_rv_q;
   logic [19:0]           vt_q [`VMT_VT_DEPTH];
   logic [15:0]           iac_q, gctl_q, w63_q, w47_q, w31_q, w15_q;
   logic [6:0]            top_q;
   logic                  pend_q, fetch_q, ack_q;
   logic [15:0]           rdata_q;
   logic [10:0]           cnt_q;
   logic [1:0]            stamp_q;
   logic [1:0]            p_port_q;
   logic [11:0]           p_vid_q;
   logic [47:0]           p_da_q, p_sa_q;
   logic                  p_st_hit_q;
   logic [2:0]            p_st_ports_q, mem_q, fwd_q;
   logic [3:0]            fid_q;
   logic                  rv_q, rdrop_q, rdy_q;
   logic [2:0]            rports_q;

   function automatic logic [9:0] hash(input logic [3:0] f,
                                       input logic [47:0] m);
      hash = m[9:0] ^ m[19:10] ^ m[29:20] ^ {6'h0, f};
   endfunction : hash

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire req      = (rl.wr | rl.rd) & ~ack_q;
   wire wr_go    = req & rl.wr;
   wire ctl_go   = wr_go & (rl.sel == `VMT_SEL_CTRL);
   wire [1:0] tbl = rl.wdata[11:10];
   wire is_rd    = rl.wdata[`VMT_IAC_READ];
   wire vt_rd_go = ctl_go & is_rd & (tbl == 2'b01);
   wire vt_wr_go = ctl_go & ~is_rd & (tbl == 2'b01);
   wire lt_rd_go = ctl_go & is_rd & (tbl == 2'b10);
   wire [3:0] vidx = rl.wdata[3:0];
   wire vmode    = gctl_q[`VMT_VLAN_MODE];
   wire empty    = (cnt_q == 11'h0);
   wire [10:0] cnt_m1 = cnt_q - 11'h1;
   wire [9:0] cnt_f = empty ? 10'h0 : cnt_m1[9:0];
   wire host_go  = pend_q & ~fetch_q & (st_q == vmt_pkg::vmt_s_idle);
   wire [9:0] da_idx = hash(fid_q, p_da_q);
   wire [9:0] sa_idx = hash(fid_q, p_sa_q);
   wire [9:0] eng_addr = (st_q == vmt_pkg::vmt_s_da) ? da_idx : sa_idx;
   wire [9:0] mem_addr = host_go ? iac_q[9:0] : eng_addr;
   wire [2:0] in_bit = 3'b001 << p_port_q;
   wire lt_match = lt_rv_q & (lt_rd_q.filter_identifier == fid_q);
   wire da_hit   = lt_match & (lt_rd_q.mac == p_da_q);
   wire sa_hit   = lt_match & (lt_rd_q.mac == p_sa_q);
   wire [2:0] hit_ports = 3'b001 << lt_rd_q.port;
   vmt_pkg::vmt_lent_type fent;
   assign fent = lt_rv_q ? lt_rd_q : '0;
   // default id when untagged or null
   wire [11:0] vid_in = (~pkt_tagged | (pkt_tag_vid == 12'h0)) ?
                        pkt_pvid : pkt_tag_vid;
   logic [15:0] rmux;
   always_comb begin
      case (rl.sel)
         `VMT_SEL_CTRL: rmux = iac_q;
         `VMT_SEL_TOP:  rmux = {8'h0, pend_q | fetch_q, top_q};
         `VMT_SEL_W63:  rmux = w63_q;
         `VMT_SEL_W47:  rmux = w47_q;
         `VMT_SEL_W31:  rmux = w31_q;
         `VMT_SEL_W15:  rmux = w15_q;
         `VMT_SEL_GCTL: rmux = gctl_q;
         default:       rmux = 16'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // VLAN table
   // ----------------------------------------------------------------
   logic [15:0] vhit;
   genvar gi;
   generate
      for (gi = 0; gi < `VMT_VT_DEPTH; gi++) begin : g_vt
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               vt_q[gi] <= `VMT_VT_RST;
            end else if (vt_wr_go && vidx == 4'(gi)) begin
               vt_q[gi] <= {w31_q[3:0], w15_q};
            end
         end
         assign vhit[gi] = vt_q[gi][`VMT_VT_VALID] &
                           (vt_q[gi][11:0] == p_vid_q);
      end
   endgenerate
   logic [19:0] vent;
   always_comb begin
      vent = '0;
      for (int i = `VMT_VT_DEPTH - 1; i >= 0; i--) begin
         if (vhit[i]) begin
            vent = vt_q[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Indirect registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {iac_q, gctl_q, w63_q, w47_q, w31_q, w15_q} <= '0;
         top_q   <= 7'h4;
         pend_q  <= 1'b0;
         fetch_q <= 1'b0;
         ack_q   <= 1'b0;
         rdata_q <= 16'h0;
      end else begin
         ack_q   <= req;
         fetch_q <= host_go;
         if (req && rl.rd) begin
            rdata_q <= rmux;
         end
         // Entry fetch wins over data writes from the link
         if (fetch_q) begin
            top_q  <= {4'h0, empty, cnt_f[9:8]};
            w63_q  <= {cnt_f[7:0], fent.stamp, fent.port, fent.filter_identifier};
            w47_q  <= fent.mac[47:32];
            w31_q  <= fent.mac[31:16];
            w15_q  <= fent.mac[15:0];
         end else if (vt_rd_go) begin
            w31_q  <= {12'h0, vt_q[vidx][19:16]};
            w15_q  <= vt_q[vidx][15:0];
         end else if (wr_go) begin
            case (rl.sel)
               `VMT_SEL_W63: w63_q <= rl.wdata;
               `VMT_SEL_W47: w47_q <= rl.wdata;
               `VMT_SEL_W31: w31_q <= rl.wdata;
               `VMT_SEL_W15: w15_q <= rl.wdata;
               default: ;
            endcase
         end
         if (ctl_go) begin
            iac_q <= rl.wdata;
         end
         if (wr_go && rl.sel == `VMT_SEL_GCTL) begin
            gctl_q <= rl.wdata;
         end
         // New read request wins over completion
         if (lt_rd_go) begin
            pend_q <= 1'b1;
         end else if (fetch_q) begin
            pend_q <= 1'b0;
         end
      end
   end
   assign rl.rdata = rdata_q;
   assign rl.ack   = ack_q;

   // ----------------------------------------------------------------
   // Learned table
   // ----------------------------------------------------------------
   wire lrn_we = (st_q == vmt_pkg::vmt_s_lrn);
   always_ff @(posedge clk_sys) begin
      if (lrn_we) begin
         lt_mem[sa_idx] <= '{stamp_q, p_port_q, fid_q, p_sa_q};
      end
      lt_rd_q <= lt_mem[mem_addr];
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lt_vld_q <= '0;
         lt_rv_q  <= 1'b0;
         cnt_q    <= 11'h0;
         stamp_q  <= 2'h0;
      end else begin
         lt_rv_q <= lt_vld_q[mem_addr];
         if (age_tick) begin
            stamp_q <= stamp_q + 2'h1;
         end
         if (lrn_we) begin
            lt_vld_q[sa_idx] <= 1'b1;
            if (!lt_rv_q) begin
               cnt_q <= cnt_q + 11'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Packet engine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= vmt_pkg::vmt_s_idle;
         {p_port_q, p_vid_q, p_da_q, p_sa_q} <= '0;
         {p_st_hit_q, p_st_ports_q, mem_q, fwd_q, fid_q} <= '0;
         {rv_q, rdrop_q, rports_q} <= '0;
         rdy_q <= 1'b0;
      end else begin
         rv_q  <= 1'b0;
         rdy_q <= 1'b0;
         case (st_q)
            vmt_pkg::vmt_s_idle: begin
               rdy_q <= ~pkt_valid;
               if (pkt_valid) begin
                  p_port_q     <= pkt_port;
                  p_vid_q      <= vid_in;
                  p_da_q       <= pkt_da;
                  p_sa_q       <= pkt_sa;
                  p_st_hit_q   <= st_hit;
                  p_st_ports_q <= st_ports;
                  st_q         <= vmt_pkg::vmt_s_vlan;
               end
            end
            vmt_pkg::vmt_s_vlan: begin
               // drop when invalid in VLAN mode
               if (vmode && vhit == 16'h0) begin
                  rv_q    <= 1'b1;
                  rdrop_q <= 1'b1;
                  rports_q <= 3'b000;
                  rdy_q   <= 1'b1;
                  st_q    <= vmt_pkg::vmt_s_idle;
               end else begin
                  fid_q <= vmode ? vent[15:12] : 4'h0;
                  mem_q <= vmode ? vent[18:16] : 3'b111;
                  st_q  <= vmt_pkg::vmt_s_da;
               end
            end
            vmt_pkg::vmt_s_da: st_q <= vmt_pkg::vmt_s_sa;
            vmt_pkg::vmt_s_sa: begin
               fwd_q <= p_st_hit_q ? p_st_ports_q :
                        da_hit ? hit_ports : (mem_q & ~in_bit);
               st_q  <= vmt_pkg::vmt_s_lrn;
            end
            vmt_pkg::vmt_s_lrn: begin
               rv_q     <= 1'b1;
               rdrop_q  <= 1'b0;
               rports_q <= fwd_q;
               rdy_q    <= 1'b1;
               st_q     <= vmt_pkg::vmt_s_idle;
            end
            default: st_q <= vmt_pkg::vmt_s_idle;
         endcase
      end
   end
   assign pkt_ready = rdy_q;
   assign res_valid = rv_q;
   assign res_drop  = rdrop_q;
   assign res_ports = rports_q;
endmodule : vmt_dev
`default_nettype wire

// *** logic/vmt_host.sv ***
/*
 Controller end: Avalon-MM slave registers for software, and sequencer
 that performs indirect table accesses over the link.
 Assumes the device acks each link request after one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vmt_consts.svh"
module vmt_host (
   // System
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // Register link
   vmt_if.host              rl,
   // Avalon-MM slave
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   vmt_pkg::vmt_hst_type  st_q;
   vmt_pkg::vmt_kind_type kind_q;
   logic [15:0] cmd_q, gctl_q;
   logic [19:0] vdat_q;
   logic [7:0]  rtop_q;
   logic [15:0] r63_q, r47_q, r31_q, r15_q;
   logic        busy_q, done_q, wait_q;
   logic [31:0] rdq_q;
   logic [2:0]  step_q, sel_q;
   logic        wr_q, rd_q;
   logic [15:0] wd_q;

   // ----------------------------------------------------------------
   // Avalon decode
   // ----------------------------------------------------------------
   wire av_go  = (avs_read | avs_write) & wait_q;
   wire wr_eff = avs_write & ~wait_q;
   wire cmd_go = wr_eff & (avs_address == `VMT_AV_CMD) & ~busy_q;
   wire gct_go = wr_eff & (avs_address == `VMT_AV_GCTL) & ~busy_q;
   wire [2:0] cop = avs_writedata[12:10];
   logic [31:0] amux;
   always_comb begin
      case (avs_address)
         `VMT_AV_CMD:    amux = {16'h0, cmd_q};
         `VMT_AV_VDATA:  amux = {12'h0, vdat_q};
         `VMT_AV_GCTL:   amux = {16'h0, gctl_q};
         `VMT_AV_STATUS: amux = {30'h0, done_q, busy_q};
         `VMT_AV_RTOP:   amux = {24'h0, rtop_q};
         `VMT_AV_RHI:    amux = {r63_q, r47_q};
         `VMT_AV_RLO:    amux = {r31_q, r15_q};
         default:        amux = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // Step table
   // ----------------------------------------------------------------
   logic        s_end, s_wr;
   logic [2:0]  s_sel;
   logic [15:0] s_wd;
   always_comb begin
      s_end = 1'b0;
      s_wr  = 1'b0;
      s_sel = `VMT_SEL_CTRL;
      s_wd  = cmd_q;
      case (kind_q)
         vmt_pkg::vmt_k_gctl: begin
            s_end = (step_q != 3'd0);
            s_wr  = 1'b1;
            s_sel = `VMT_SEL_GCTL;
            s_wd  = gctl_q;
         end
         // high word, low word, then control
         vmt_pkg::vmt_k_vwr: begin
            s_end = (step_q == 3'd3);
            s_wr  = 1'b1;
            case (step_q)
               3'd0: begin
                  s_sel = `VMT_SEL_W31;
                  s_wd  = {12'h0, vdat_q[19:16]};
               end
               3'd1: begin
                  s_sel = `VMT_SEL_W15;
                  s_wd  = vdat_q[15:0];
               end
               default: ;
            endcase
         end
         vmt_pkg::vmt_k_vrd: begin
            s_end = (step_q == 3'd3);
            s_wr  = (step_q == 3'd0);
            s_sel = (step_q == 3'd1) ? `VMT_SEL_W31 :
                    (step_q == 3'd2) ? `VMT_SEL_W15 : `VMT_SEL_CTRL;
         end
         default: begin
            s_end = (step_q == 3'd6);
            s_wr  = (step_q == 3'd0);
            s_sel = (step_q == 3'd0) ? `VMT_SEL_CTRL : step_q;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers and sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {cmd_q, gctl_q, vdat_q, rtop_q} <= '0;
         {r63_q, r47_q, r31_q, r15_q} <= '0;
         {busy_q, done_q, rdq_q, step_q} <= '0;
         {sel_q, wr_q, rd_q, wd_q} <= '0;
         wait_q <= 1'b1;
         kind_q <= vmt_pkg::vmt_k_gctl;
         st_q   <= vmt_pkg::vmt_h_idle;
      end else begin
         wait_q <= ~av_go;
         if (av_go) begin
            rdq_q <= amux;
         end
         if (wr_eff && avs_address == `VMT_AV_VDATA) begin
            vdat_q <= avs_writedata[19:0];
         end
         // Static and counter tables are not served: finish at once
         if (cmd_go) begin
            cmd_q  <= avs_writedata[15:0];
            done_q <= ~(cop == 3'b101 || cop == 3'b001 || cop == 3'b110);
            busy_q <= (cop == 3'b101 || cop == 3'b001 || cop == 3'b110);
            kind_q <= (cop == 3'b001) ? vmt_pkg::vmt_k_vwr :
                      (cop == 3'b101) ? vmt_pkg::vmt_k_vrd :
                                        vmt_pkg::vmt_k_lrd;
            step_q <= 3'd0;
            st_q   <= vmt_pkg::vmt_h_next;
         end else if (gct_go) begin
            gctl_q <= avs_writedata[15:0];
            busy_q <= 1'b1;
            done_q <= 1'b0;
            kind_q <= vmt_pkg::vmt_k_gctl;
            step_q <= 3'd0;
            st_q   <= vmt_pkg::vmt_h_next;
         end else begin
            case (st_q)
               vmt_pkg::vmt_h_idle: ;
               vmt_pkg::vmt_h_next: begin
                  if (!busy_q || s_end) begin
                     busy_q <= 1'b0;
                     // Unserved codes were marked done at the command
                     done_q <= 1'b1;
                     st_q   <= vmt_pkg::vmt_h_idle;
                  end else begin
                     sel_q <= s_sel;
                     wr_q  <= s_wr;
                     rd_q  <= ~s_wr;
                     wd_q  <= s_wd;
                     st_q  <= vmt_pkg::vmt_h_req;
                  end
               end
               vmt_pkg::vmt_h_req: begin
                  if (rl.ack) begin
                     wr_q <= 1'b0;
                     rd_q <= 1'b0;
                     st_q <= vmt_pkg::vmt_h_next;
                     case (sel_q)
                        `VMT_SEL_TOP: rtop_q <= rl.rdata[7:0];
                        `VMT_SEL_W63: r63_q  <= rl.rdata;
                        `VMT_SEL_W47: r47_q  <= rl.rdata;
                        `VMT_SEL_W31: r31_q  <= rl.rdata;
                        `VMT_SEL_W15: r15_q  <= rl.rdata;
                        default: ;
                     endcase
                     // reread top byte while not ready
                     if (!(rd_q && sel_q == `VMT_SEL_TOP &&
                           rl.rdata[`VMT_TOP_BUSY])) begin
                        step_q <= step_q + 3'd1;
                     end
                  end
               end
               default: st_q <= vmt_pkg::vmt_h_idle;
            endcase
         end
      end
   end
   assign rl.sel          = sel_q;
   assign rl.wr           = wr_q;
   assign rl.rd           = rd_q;
   assign rl.wdata        = wd_q;
   assign avs_readdata    = rdq_q;
   assign avs_waitrequest = wait_q;
endmodule : vmt_host
`default_nettype wire

// *** dv/vmt_link_monitor.sv ***
/* Checker for the indirect register link between the two ends.
   Assumes one clk_sys domain and an active low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module vmt_link_monitor (
   // System
   input wire logic        clk_sys,
   input wire logic        resetn,
   // Link
   input wire logic [2:0]  sel,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        ack
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_req; (wr || rd) && !ack; endsequence
   sequence s_ans; ack ##1 !ack; endsequence
   property p_ack_after; s_req |=> s_ans; endproperty
   a_ack_after: assert property (p_ack_after)
      else $error("link request not answered next cycle");
   property p_ack_pulse; ack |=> !ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("link ack longer than one cycle");
   property p_no_spur; ack |-> $past(wr || rd); endproperty
   a_no_spur: assert property (p_no_spur)
      else $error("link ack without request");
   property p_hold;
      s_req |=> $stable(sel) && $stable(wr) && $stable(rd) && $stable(wdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("link request changed before ack");
   property p_drop; ack |=> !wr && !rd; endproperty
   a_drop: assert property (p_drop)
      else $error("link request kept after ack");
   property p_excl; !(wr && rd); endproperty
   a_excl: assert property (p_excl)
      else $error("link read and write together");
   property p_rdata; $changed(rdata) |-> ack && $past(rd); endproperty
   a_rdata: assert property (p_rdata)
      else $error("link read data moved outside a read answer");
   property p_sel; (wr || rd) |-> sel <= 3'h6; endproperty
   a_sel: assert property (p_sel)
      else $error("link select out of range");
endmodule : vmt_link_monitor
`default_nettype wire

// *** dv/vlan_mac_table_lookup_test.sv ***
/* Bench joining controller and lookup device over the link.
   Assumes the controller's Avalon word offsets. */
`timescale 1ns/1ps
`default_nettype none
module vlan_mac_table_lookup_test;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pkt_valid = 1'b0;
   logic        pkt_tagged = 1'b0;
   logic [1:0]  pkt_port = 2'h0;
   logic [11:0] pkt_tag_vid = 12'h0;
   logic [47:0] pkt_sa = 48'h5;
   logic        st_hit = 1'b0;
   logic [2:0]  st_ports = 3'h0;
   logic        age_tick = 1'b0;
   logic        pkt_ready, res_valid, res_drop;
   logic [2:0]  res_ports;
   logic [31:0] rdv;
   int          failures = 0, check_count = 0, cycles = 0;
   vmt_if rl ();
   vmt_dev u_vmt_dev (.clk_sys(clk_sys), .resetn(resetn), .rl(rl),
      .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_tagged(pkt_tagged),
      .pkt_tag_vid(pkt_tag_vid), .pkt_pvid(12'h001), .pkt_da(48'h0a0b),
      .pkt_sa(pkt_sa), .st_hit(st_hit), .st_ports(st_ports),
      .age_tick(age_tick),
      .pkt_ready(pkt_ready), .res_valid(res_valid), .res_drop(res_drop),
      .res_ports(res_ports));
   vmt_host u_vmt_host (.clk_sys(clk_sys), .resetn(resetn), .rl(rl),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   vmt_link_monitor u_vmt_link_monitor (.clk_sys(clk_sys),
      .resetn(resetn), .sel(rl.sel), .wr(rl.wr), .rd(rl.rd),
      .wdata(rl.wdata), .rdata(rl.rdata), .ack(rl.ack));
   always #12.5 clk_sys = ~clk_sys;
   // Whole run needs a few hundred cycles; the ceiling leaves ample room
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end
   task results;
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Request holds until the rising edge that sees waitrequest low
   task av(input logic [2:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task op(input logic [15:0] cmd);
      av(3'h0, 1'b1, {16'h0, cmd});
      do av(3'h3, 1'b0, 32'h0); while (rdv[1:0] !== 2'b10);
   endtask : op
   task pkt(input logic [1:0] port, input logic tag, input logic [11:0] vlan_identifier);
      do @(negedge clk_sys); while (pkt_ready !== 1'b1);
      @(posedge clk_sys);
      pkt_port <= port;
      pkt_tagged <= tag;
      pkt_tag_vid <= vlan_identifier;
      pkt_valid <= 1'b1;
      @(posedge clk_sys);
      pkt_valid <= 1'b0;
      do @(negedge clk_sys); while (res_valid !== 1'b1);
   endtask : pkt
   task t_reset_tables;
      op(16'h1402);
      av(3'h6, 1'b0, 32'h0);
      chk(rdv, 32'h000f0001);
      op(16'h1800);
      av(3'h4, 1'b0, 32'h0);
      chk(rdv, 32'h00000004);
   endtask : t_reset_tables
   task t_vlan_write;
      av(3'h1, 1'b1, 32'h000b5123);
      op(16'h0406);
      op(16'h1406);
      av(3'h6, 1'b0, 32'h0);
      chk(rdv, 32'h000b5123);
   endtask : t_vlan_write
   task t_packets;
      pkt(2'h0, 1'b1, 12'h055);
      chk({28'h0, res_drop, res_ports}, 32'h6);
      av(3'h2, 1'b1, 32'h00008000);
      do av(3'h3, 1'b0, 32'h0); while (rdv[1:0] !== 2'b10);
      pkt(2'h0, 1'b1, 12'h055);
      chk({31'h0, res_drop}, 32'h1);
      pkt(2'h1, 1'b0, 12'h000);
      chk({28'h0, res_drop, res_ports}, 32'h5);
      @(posedge clk_sys);
      age_tick <= 1'b1;
      @(posedge clk_sys);
      age_tick <= 1'b0;
      pkt(2'h1, 1'b1, 12'h000);
      chk({28'h0, res_drop, res_ports}, 32'h5);
      st_hit <= 1'b1;
      st_ports <= 3'h4;
      pkt(2'h1, 1'b0, 12'h000);
      chk({28'h0, res_drop, res_ports}, 32'h4);
      st_hit <= 1'b0;
      op(16'h1805);
      av(3'h4, 1'b0, 32'h0);
      chk(rdv, 32'h0);
      av(3'h5, 1'b0, 32'h0);
      chk(rdv, 32'h00500000);
      av(3'h6, 1'b0, 32'h0);
      chk(rdv, 32'h00000005);
   endtask : t_packets
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset_tables();
      t_vlan_write();
      t_packets();
      results();
   end
endmodule : vlan_mac_table_lookup_test
`default_nettype wire
